// ==== design/sgss_blend.sv ====
// per-gain linear blend between set 1 and set 2 by a 0..1.0 weight
`timescale 1ns/1ps
`include "sgss_cfg.svh"
module sgss_blend (
  input wire logic clk_i,
  input wire logic rst_i,
  sgss_blend_if.blend bus
);
  sgss_pkg::sgss_gain_t next_gain [`SGSS_NUM_GAINS];

  for (genvar i = 0; i < `SGSS_NUM_GAINS; i++) begin : g_gain
    logic signed [16:0] diff;
    logic signed [34:0] prod;
    logic signed [34:0] sum;
    sgss_pkg::sgss_weight_t w;
    always_comb begin
      // model-following values follow their own selection, never the ramp [R4]
      w = (i == `SGSS_IDX_MF_GAIN || i == `SGSS_IDX_MF_COMP) ? bus.w_mf : bus.w_main;
      diff = $signed({1'b0, bus.val2[i]}) - $signed({1'b0, bus.val1[i]});
      prod = diff * $signed({1'b0, w});
      sum = $signed({19'h00000, bus.val1[i]}) + (prod >>> 16);
      next_gain[i] = sum[15:0]; // [R3] [R11]
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        bus.gain[i] <= 16'h0000;
      end else begin
        bus.gain[i] <= next_gain[i];
      end
    end
  end
endmodule

// ==== design/sgss_switcher.sv ====
// servo gain set switcher: register file, manual and automatic gain switching
// Function
// (R1) Mode digit 0 selects manual, 2 automatic switching; 1 is reserved.
// (R2) Manual: gain-select bit 0 applies set 1, bit 1 applies set 2.
// (R3) Each set holds seven gains; set 2 replaces every set 1 value.
// (R4) Model-following gain and compensation switch only under manual switching.
// (R5) Model-following pair switches only with no command running and motor stopped.
// (R6) Automatic switching acts only in position control mode.
// (R7) Condition A true moves to set 2 with times 1; false back with times 2.
// (R8) Condition codes: completed on/off, near on/off, filter idle, reference on.
// (R9) Automatic mode outside position control: codes 0,2,4 hold set 1, others set 2.
// (R10) Transition starts after the waiting time of its direction.
// (R11) Gains move linearly to new values within the switching time.
// (R12) Automatic switching only with PI or I-P speed control.
// (R13) Condition reverting during the wait cancels the pending transition.
// (R14) Mode and condition digit changes act on the next cycle, no restart.
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "sgss_cfg.svh"
module sgss_switcher #(
  parameter int TICK_CYCLES = `SGSS_TIME_UNIT_NS / `SGSS_CLK_PERIOD_NS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic gain_select_i,
  input wire logic command_busy_i,
  input wire logic motor_stopped_i,
  input wire logic position_control_i,
  input wire logic positioning_completed_i,
  input wire logic positioning_near_i,
  input wire logic ref_filter_idle_i,
  input wire logic ref_input_on_i,
  output logic [15:0] speed_loop_gain_o,
  output logic [15:0] speed_integral_time_o,
  output logic [15:0] position_loop_gain_o,
  output logic [15:0] torque_filter_time_o,
  output logic [15:0] model_follow_gain_o,
  output logic [15:0] model_follow_comp_o,
  output logic [15:0] friction_comp_gain_o,
  output logic gain_set2_o
);
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam sgss_pkg::sgss_gain_t GAIN_RST [`SGSS_NUM_GAINS] = '{
    `SGSS_RST_SPD_GAIN, `SGSS_RST_SPD_INTEG, `SGSS_RST_POS_GAIN, `SGSS_RST_TRQ_FILT,
    `SGSS_RST_MF_GAIN, `SGSS_RST_MF_COMP, `SGSS_RST_FRICTION};

  // synchronised pins
  logic [7:0] pins;
  logic gsel, cmd_busy, stopped, pos_ctrl, positioning_completed, near, filt_idle, ref_on;
  sgss_sync #(.WIDTH(8)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({gain_select_i, command_busy_i, motor_stopped_i, position_control_i,
          positioning_completed_i, positioning_near_i, ref_filter_idle_i, ref_input_on_i}),
    .q_o(pins)
  );
  assign {gsel, cmd_busy, stopped, pos_ctrl, positioning_completed, near, filt_idle, ref_on} = pins;

  // register file
  logic [31:0] gain_switch_config, next_config;
  logic [15:0] switch_wait_time_1, switch_wait_time_2, switch_ramp_time_1, switch_ramp_time_2;
  logic [31:0] next_wait, next_ramp;
  sgss_pkg::sgss_gain_t gain1 [`SGSS_NUM_GAINS];
  sgss_pkg::sgss_gain_t gain2 [`SGSS_NUM_GAINS];
  sgss_pkg::sgss_gain_t next_gain1 [`SGSS_NUM_GAINS];
  sgss_pkg::sgss_gain_t next_gain2 [`SGSS_NUM_GAINS];
  logic [31:0] next_dat;
  logic next_ack;
  logic [31:0] status;
  logic req, wr;
  logic [5:0] widx;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // control state
  sgss_pkg::sgss_state_e state, next_state;
  logic tgt, next_tgt, mf_sel, next_mf;
  logic [15:0] cnt, next_cnt, len, next_len;
  sgss_pkg::sgss_weight_t w, next_w, w_start, next_w_start;
  logic [TICK_W-1:0] tick_cnt, next_tick_cnt;
  logic tick;
  logic [3:0] mode, cond;
  logic [1:0] spd_type;
  logic cond_a, auto_ok, go_ramp, frac_clr, div_go;
  logic [15:0] wait_dir, ramp_dir, elapsed;
  logic signed [17:0] dw;
  logic signed [35:0] wprod;
  logic signed [35:0] wsum;

  // divider state: frac = elapsed * 65536 / len
  logic div_run, next_div_run;
  logic [3:0] div_cnt, next_div_cnt;
  logic [15:0] div_rem, next_div_rem, div_q, next_div_q;
  sgss_pkg::sgss_weight_t frac, next_frac;
  logic [16:0] r2;

  always_comb begin
    req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wr = req && wb_we_i;
    widx = wb_adr_i[7:2] - `SGSS_ADR_GAIN_BASE;
    status = 32'h0000_0000;
    status[`SGSS_STS_TARGET] = tgt;
    status[`SGSS_STS_WAITING] = (state == sgss_pkg::SGSS_WAITING);
    status[`SGSS_STS_RAMPING] = (state == sgss_pkg::SGSS_RAMPING);
    status[`SGSS_STS_MF_SET2] = mf_sel;
    status[`SGSS_STS_AUTO_ON] = auto_ok;
    status[`SGSS_STS_WEIGHT_LSB +: 17] = w;
    next_ack = req;
    next_dat = wb_dat_o;
    next_config = gain_switch_config;
    next_wait = {switch_wait_time_2, switch_wait_time_1};
    next_ramp = {switch_ramp_time_2, switch_ramp_time_1};
    next_gain1 = gain1;
    next_gain2 = gain2;
    if (req) begin
      next_dat = 32'h0000_0000;
      unique case (wb_adr_i[7:2])
        `SGSS_ADR_CONFIG: next_dat = gain_switch_config;
        `SGSS_ADR_STATUS: next_dat = status;
        `SGSS_ADR_WAIT: next_dat = {switch_wait_time_2, switch_wait_time_1};
        `SGSS_ADR_RAMP: next_dat = {switch_ramp_time_2, switch_ramp_time_1};
        default: begin
          if (widx < 6'(`SGSS_NUM_GAINS)) begin
            next_dat = {gain2[widx[2:0]], gain1[widx[2:0]]};
          end
        end
      endcase
    end
    if (wr) begin
      unique case (wb_adr_i[7:2])
        `SGSS_ADR_CONFIG: next_config = merge(gain_switch_config, wb_dat_i, wb_sel_i) & `SGSS_CFG_MASK; // [R14]
        `SGSS_ADR_WAIT: next_wait = merge(next_wait, wb_dat_i, wb_sel_i);
        `SGSS_ADR_RAMP: next_ramp = merge(next_ramp, wb_dat_i, wb_sel_i);
        default: begin
          if (widx < 6'(`SGSS_NUM_GAINS)) begin
            {next_gain2[widx[2:0]], next_gain1[widx[2:0]]} =
              merge({gain2[widx[2:0]], gain1[widx[2:0]]}, wb_dat_i, wb_sel_i);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      gain_switch_config <= `SGSS_RST_CONFIG;
      switch_wait_time_1 <= `SGSS_RST_TIMES;
      switch_wait_time_2 <= `SGSS_RST_TIMES;
      switch_ramp_time_1 <= `SGSS_RST_TIMES;
      switch_ramp_time_2 <= `SGSS_RST_TIMES;
      gain1 <= GAIN_RST;
      gain2 <= GAIN_RST;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      gain_switch_config <= next_config;
      {switch_wait_time_2, switch_wait_time_1} <= next_wait;
      {switch_ramp_time_2, switch_ramp_time_1} <= next_ramp;
      gain1 <= next_gain1;
      gain2 <= next_gain2;
    end
  end

  // switching control
  always_comb begin
    mode = gain_switch_config[`SGSS_CFG_MODE_LSB +: 4];
    cond = gain_switch_config[`SGSS_CFG_COND_LSB +: 4];
    spd_type = gain_switch_config[`SGSS_CFG_SPD_LSB +: 2];
    tick = (tick_cnt == TICK_LAST);
    next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
    unique case (cond) // [R8]
      `SGSS_COND_POSITIONING_COMPLETED_ON: cond_a = positioning_completed;
      `SGSS_COND_POSITIONING_COMPLETED_OFF: cond_a = !positioning_completed;
      `SGSS_COND_NEAR_ON: cond_a = near;
      `SGSS_COND_NEAR_OFF: cond_a = !near;
      `SGSS_COND_FILT_IDLE: cond_a = filt_idle && !ref_on;
      `SGSS_COND_REF_ON: cond_a = ref_on;
      default: cond_a = 1'b0;
    endcase
    auto_ok = (mode == `SGSS_MODE_AUTO) && pos_ctrl && // [R6]
              (spd_type == `SGSS_SPD_PI || spd_type == `SGSS_SPD_IP); // [R12]
    wait_dir = cond_a ? switch_wait_time_1 : switch_wait_time_2; // [R7]
    ramp_dir = cond_a ? switch_ramp_time_1 : switch_ramp_time_2; // [R7]
    elapsed = cnt + 16'h0001;
    dw = $signed({1'b0, (tgt ? `SGSS_WEIGHT_FULL : 17'h00000)}) - $signed({1'b0, w_start});
    wprod = dw * $signed({1'b0, frac});
    wsum = $signed({19'h00000, w_start}) + (wprod >>> 16);
    next_state = state;
    next_tgt = tgt;
    next_mf = mf_sel;
    next_cnt = cnt;
    next_len = len;
    next_w = w;
    next_w_start = w_start;
    go_ramp = 1'b0;
    frac_clr = 1'b0;
    div_go = 1'b0;
    if (mode == `SGSS_MODE_MANUAL) begin // [R1]
      next_state = sgss_pkg::SGSS_IDLE;
      next_tgt = gsel; // [R2]
      next_w = gsel ? `SGSS_WEIGHT_FULL : 17'h00000; // [R2]
      if (gsel != mf_sel && !cmd_busy && stopped) begin
        next_mf = gsel; // [R5]
      end
    end else if (mode == `SGSS_MODE_AUTO && !pos_ctrl) begin
      next_state = sgss_pkg::SGSS_IDLE;
      next_tgt = cond[0]; // [R9]
      next_w = cond[0] ? `SGSS_WEIGHT_FULL : 17'h00000; // [R9]
    end else if (auto_ok) begin
      unique case (state)
        sgss_pkg::SGSS_IDLE: begin
          if (cond_a != tgt) begin
            next_cnt = 16'h0000;
            if (wait_dir == 16'h0000) begin
              go_ramp = 1'b1;
            end else begin
              next_state = sgss_pkg::SGSS_WAITING; // [R10]
              // restart the time base so the wait lasts whole ticks, never less [R10]
              next_tick_cnt = '0;
            end
          end
        end
        sgss_pkg::SGSS_WAITING: begin
          if (cond_a == tgt) begin
            next_state = sgss_pkg::SGSS_IDLE; // [R13]
          end else if (tick) begin
            next_cnt = elapsed;
            if (elapsed >= wait_dir) begin
              go_ramp = 1'b1; // [R10]
            end
          end
        end
        sgss_pkg::SGSS_RAMPING: begin
          next_w = wsum[16:0]; // [R11]
          if (tick) begin
            next_cnt = elapsed;
            if (elapsed >= len) begin
              next_w = tgt ? `SGSS_WEIGHT_FULL : 17'h00000; // [R11]
              next_state = sgss_pkg::SGSS_IDLE;
            end else begin
              div_go = 1'b1;
            end
          end
        end
      endcase
    end else begin
      next_state = sgss_pkg::SGSS_IDLE; // reserved mode or other speed control: hold
    end
    if (go_ramp) begin
      next_tgt = cond_a; // [R7]
      next_w_start = w;
      next_cnt = 16'h0000;
      next_len = ramp_dir;
      frac_clr = 1'b1;
      // ramp steps counted from the start of the ramp [R11]
      next_tick_cnt = '0;
      if (ramp_dir == 16'h0000) begin
        next_w = cond_a ? `SGSS_WEIGHT_FULL : 17'h00000;
        next_state = sgss_pkg::SGSS_IDLE;
      end else begin
        next_state = sgss_pkg::SGSS_RAMPING;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= sgss_pkg::SGSS_IDLE;
      tgt <= 1'b0;
      mf_sel <= 1'b0;
      cnt <= 16'h0000;
      len <= 16'h0000;
      w <= 17'h00000;
      w_start <= 17'h00000;
      tick_cnt <= '0;
    end else begin
      state <= next_state;
      tgt <= next_tgt;
      mf_sel <= next_mf;
      cnt <= next_cnt;
      len <= next_len;
      w <= next_w;
      w_start <= next_w_start;
      tick_cnt <= next_tick_cnt;
    end
  end

  // serial restoring divider, 16 cycles per ramp step
  always_comb begin
    next_div_run = div_run;
    next_div_cnt = div_cnt;
    next_div_rem = div_rem;
    next_div_q = div_q;
    next_frac = frac;
    r2 = {div_rem, 1'b0};
    if (frac_clr) begin
      next_frac = 17'h00000;
      next_div_run = 1'b0;
    end else if (div_go) begin
      next_div_rem = elapsed;
      next_div_q = 16'h0000;
      next_div_cnt = 4'h0;
      next_div_run = 1'b1;
    end else if (div_run) begin
      if (r2 >= {1'b0, len}) begin
        next_div_rem = 16'(r2 - {1'b0, len});
        next_div_q = {div_q[14:0], 1'b1};
      end else begin
        next_div_rem = r2[15:0];
        next_div_q = {div_q[14:0], 1'b0};
      end
      next_div_cnt = div_cnt + 4'h1;
      if (div_cnt == 4'hf) begin
        next_div_run = 1'b0;
        next_frac = {1'b0, next_div_q};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_run <= 1'b0;
      div_cnt <= 4'h0;
      div_rem <= 16'h0000;
      div_q <= 16'h0000;
      frac <= 17'h00000;
    end else begin
      div_run <= next_div_run;
      div_cnt <= next_div_cnt;
      div_rem <= next_div_rem;
      div_q <= next_div_q;
      frac <= next_frac;
    end
  end

  // gain blending
  sgss_blend_if u_if ();
  assign u_if.val1 = gain1; // [R3]
  assign u_if.val2 = gain2; // [R3]
  assign u_if.w_main = w;
  assign u_if.w_mf = mf_sel ? `SGSS_WEIGHT_FULL : 17'h00000; // [R4]
  sgss_blend u_blend (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bus(u_if.blend)
  );
  assign speed_loop_gain_o = u_if.gain[`SGSS_IDX_SPD_GAIN];
  assign speed_integral_time_o = u_if.gain[`SGSS_IDX_SPD_INTEG];
  assign position_loop_gain_o = u_if.gain[`SGSS_IDX_POS_GAIN];
  assign torque_filter_time_o = u_if.gain[`SGSS_IDX_TRQ_FILT];
  assign model_follow_gain_o = u_if.gain[`SGSS_IDX_MF_GAIN];
  assign model_follow_comp_o = u_if.gain[`SGSS_IDX_MF_COMP];
  assign friction_comp_gain_o = u_if.gain[`SGSS_IDX_FRICTION];
  assign gain_set2_o = tgt;
endmodule

// ==== design/sgss_sync.sv ====
// two flip-flop synchronisers for pin inputs
`timescale 1ns/1ps
module sgss_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    always_comb begin
      next_meta[b] = d_i[b];
      next_q[b] = meta[b];
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        meta[b] <= 1'b0;
        q_o[b] <= 1'b0;
      end else begin
        meta[b] <= next_meta[b];
        q_o[b] <= next_q[b];
      end
    end
  end
endmodule

// ==== dv/servo_gain_set_switcher_tb_top.sv ====
// self-checking bench for the servo gain set switcher
`timescale 1ns/1ps
module servo_gain_set_switcher_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] sel = 4'hf;
  logic [3:0] be = 4'hf;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, set2, gsel, busy, stopped;
  logic pos_ctl = 1'b0;
  logic [3:0] pins = 4'h0;
  logic [15:0] g [7];
  int s1 [7] = '{16'h0190, 16'h07d0, 16'h0190, 16'h0064, 16'h01f4, 16'h03e8, 16'h0064};
  int s2 [7] = '{16'h0190, 16'h07d0, 16'h0190, 16'h0064, 16'h01f4, 16'h03e8, 16'h0064};
  int fails = 0;
  int compares = 0;
  int seed = 32'h410d;
  // pins {completed, near, filter idle, ref on} making each condition code true or false
  logic [3:0] pin_t [6] = '{4'h8, 4'h0, 4'h4, 4'h0, 4'h2, 4'h1};
  logic [3:0] pin_f [6] = '{4'h0, 4'h8, 4'h0, 4'h4, 4'h0, 4'h0};
  always #2 clk_i = !clk_i;
  sgss_host_model host (
    .clk_i(clk_i),
    .gain_select_o(gsel),
    .command_busy_o(busy),
    .motor_stopped_o(stopped)
  );
  sgss_switcher #(.TICK_CYCLES(32)) dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(wdat),
    .wb_dat_o(rdat),
    .wb_ack_o(ack),
    .gain_select_i(gsel),
    .command_busy_i(busy),
    .motor_stopped_i(stopped),
    .position_control_i(pos_ctl),
    .positioning_completed_i(pins[3]),
    .positioning_near_i(pins[2]),
    .ref_filter_idle_i(pins[1]),
    .ref_input_on_i(pins[0]),
    .speed_loop_gain_o(g[0]),
    .speed_integral_time_o(g[1]),
    .position_loop_gain_o(g[2]),
    .torque_filter_time_o(g[3]),
    .model_follow_gain_o(g[4]),
    .model_follow_comp_o(g[5]),
    .friction_comp_gain_o(g[6]),
    .gain_set2_o(set2)
  );
  task automatic complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {a, 2'b00};
    wdat <= d;
    sel <= be;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      fails++;
      complete_run();
    end
  endtask
  // main gains follow one set, the model-following pair its own
  task automatic gains(input int main, input int mf);
    for (int i = 0; i < 7; i++) begin
      check("gain", {16'h0000, g[i]}, (((i == 4 || i == 5) ? mf : main) != 0) ? s2[i] : s1[i]);
    end
    check("set2", {31'h0, set2}, main);
  endtask
  task automatic wait_set(input logic e, input int lim);
    int n = 0;
    while (set2 !== e && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    check("set2 wait", {31'h0, set2}, {31'h0, e});
    if (set2 !== e) complete_run();
    repeat (4) @(posedge clk_i);
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    gains(0, 0);
    wb(0, 6'h04, 32'h0);
    check("gain reg", q, 32'h0190_0190);
    wb(1, 6'h00, 32'hffff_ffff);
    wb(0, 6'h00, 32'h0);
    check("config", q, 32'h0000_03ff);
    wb(1, 6'h00, 32'h0);
    wb(1, 6'h01, 32'hffff_ffff);
    wb(0, 6'h01, 32'h0);
    check("status", q, 32'h0);
    wb(1, 6'h3f, 32'hffff_ffff);
    wb(0, 6'h3f, 32'h0);
    check("unmapped", q, 32'h0);
    be = 4'h3;
    wb(1, 6'h04, 32'hffff_1234);
    be = 4'hf;
    wb(0, 6'h04, 32'h0);
    check("byte merge", q, 32'h0190_1234);
    for (int i = 0; i < 7; i++) begin
      s1[i] = $random(seed) & 32'h7fff;
      s2[i] = s1[i] + 32'h100;
      wb(1, 6'h04 + i[5:0], {s2[i][15:0], s1[i][15:0]});
    end
    host.send_option(1'b1);
    wait_set(1'b1, 20);
    gains(1, 1);
    host.run_command(1'b1);
    host.send_option(1'b0);
    wait_set(1'b0, 20);
    gains(0, 1);
    host.run_command(1'b0);
    repeat (8) @(posedge clk_i);
    gains(0, 0);
    wb(1, 6'h00, 32'h1);
    host.send_option(1'b1);
    repeat (10) @(posedge clk_i);
    gains(0, 0);
    for (int c = 0; c < 6; c++) begin
      wb(1, 6'h00, {24'h0, c[3:0], 4'h2});
      repeat (8) @(posedge clk_i);
      gains(c & 1, 0);
    end
    wb(1, 6'h02, 32'h0001_0002);
    wb(1, 6'h03, 32'h0002_0004);
    wb(1, 6'h00, 32'h2);
    pos_ctl <= 1'b1;
    pins <= 4'h8;
    repeat (20) @(posedge clk_i);
    pins <= 4'h0;
    repeat (120) @(posedge clk_i);
    check("cancel", {31'h0, set2}, 32'h0);
    pins <= 4'h8;
    repeat (25) @(posedge clk_i);
    check("waiting", {31'h0, set2}, 32'h0);
    wait_set(1'b1, 80);
    repeat (56) @(posedge clk_i);
    check("ramp mid", {31'h0, g[2] > s1[2][15:0] && g[2] < s2[2][15:0]}, 32'h1);
    repeat (100) @(posedge clk_i);
    gains(1, 0);
    pins <= 4'h0;
    wait_set(1'b0, 60);
    repeat (90) @(posedge clk_i);
    gains(0, 0);
    wb(1, 6'h00, 32'h0000_0202);
    pins <= 4'h8;
    repeat (150) @(posedge clk_i);
    check("pi only", {31'h0, set2}, 32'h0);
    wb(1, 6'h02, 32'h0);
    wb(1, 6'h03, 32'h0);
    for (int c = 0; c < 6; c++) begin
      wb(1, 6'h00, {22'h0, 1'b0, c[0], c[3:0], 4'h2}); // odd codes under I-P speed control
      pins <= pin_f[c];
      repeat (12) @(posedge clk_i);
      check("cond off", {31'h0, set2}, 32'h0);
      pins <= pin_t[c];
      repeat (12) @(posedge clk_i);
      check("cond on", {31'h0, set2}, 32'h1);
    end
    repeat (700) @(posedge clk_i);
    complete_run();
  end
endmodule

// ==== dv/sgss_assertions.sv ====
// concurrent checks on the gain set switcher ports
`timescale 1ns/1ps
`include "sgss_cfg.svh"
module sgss_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic gain_select_i,
  input wire logic command_busy_i,
  input wire logic motor_stopped_i,
  input wire logic position_control_i,
  input wire logic positioning_completed_i,
  input wire logic positioning_near_i,
  input wire logic ref_filter_idle_i,
  input wire logic ref_input_on_i,
  input wire logic [15:0] speed_loop_gain_o,
  input wire logic [15:0] position_loop_gain_o,
  input wire logic [15:0] model_follow_gain_o,
  input wire logic [15:0] model_follow_comp_o,
  input wire logic gain_set2_o
);
  logic [7:0] pins;
  logic [3:0] mf_hold;
  logic [8:0] calm;
  logic [9:0] still;
  assign pins = {gain_select_i, command_busy_i, motor_stopped_i, position_control_i,
                 positioning_completed_i, positioning_near_i, ref_filter_idle_i, ref_input_on_i};
  // saturating quiet-time counters
  always_ff @(posedge clk_i) begin
    mf_hold <= (rst_i || wb_cyc_i || (!command_busy_i && motor_stopped_i)) ? 4'h0 : mf_hold + {3'h0, mf_hold != 4'hf};
    calm <= (rst_i || wb_cyc_i || $changed(gain_set2_o)) ? 9'h000 : calm + {8'h00, calm != 9'h1ff};
    still <= (rst_i || wb_cyc_i || !$stable(pins)) ? 10'h000 : still + {9'h000, still != 10'h3ff};
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_cleared;
    speed_loop_gain_o == 16'h0000 && model_follow_gain_o == 16'h0000 && !wb_ack_o && !gain_set2_o;
  endsequence
  sequence s_set1;
    speed_loop_gain_o == `SGSS_RST_SPD_GAIN && position_loop_gain_o == `SGSS_RST_POS_GAIN &&
      model_follow_gain_o == `SGSS_RST_MF_GAIN && model_follow_comp_o == `SGSS_RST_MF_COMP;
  endsequence
  a_ack_answer: assert property (s_req |=> s_pulse)
    else $error("request not answered by a one-cycle ack");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_ack_idle: assert property (!wb_cyc_i [*2] |-> !wb_ack_o)
    else $error("ack while bus idle");
  a_reset_clear: assert property ($fell(rst_i) |-> s_cleared)
    else $error("outputs not cleared by reset");
  a_reset_set1: assert property ($fell(rst_i) |-> ##[1:2] s_set1)
    else $error("set 1 reset gains not applied after reset");
  a_mf_hold: assert property (mf_hold >= 4'h8 |-> $stable(model_follow_gain_o) && $stable(model_follow_comp_o))
    else $error("model-following gains moved while busy or moving");
  a_gains_settle: assert property (calm >= 9'd300 |-> $stable(speed_loop_gain_o) && $stable(position_loop_gain_o))
    else $error("gains still moving long after a set change");
  a_set_settle: assert property (still >= 10'd600 |-> $stable(gain_set2_o))
    else $error("gain set changed with inputs long quiet");
  a_mf_idle_only: assert property ($changed(model_follow_gain_o) |->
    $past(!command_busy_i && motor_stopped_i, 4) || $past(wb_cyc_i, 2))
    else $error("model-following gain switched while busy or moving");
endmodule
bind sgss_switcher sgss_assertions chk (.*);

// ==== dv/sgss_host_model.sv ====
// host motion controller: option field gain select and command activity
`timescale 1ns/1ps
module sgss_host_model (
  input wire logic clk_i,
  output logic gain_select_o,
  output logic command_busy_o,
  output logic motor_stopped_o
);
  initial begin
    gain_select_o = 1'b0;
    command_busy_o = 1'b0;
    motor_stopped_o = 1'b1;
  end
  // option field bit: 0 asks for set 1, 1 for set 2
  task automatic send_option(input logic sel);
    @(posedge clk_i);
    gain_select_o <= sel;
  endtask
  // a running command keeps the axis moving
  task automatic run_command(input logic on);
    @(posedge clk_i);
    command_busy_o <= on;
    motor_stopped_o <= !on;
  endtask
endmodule

// ==== pkg/sgss_blend_if.sv ====
// interface between the switcher control and the gain blender
`timescale 1ns/1ps
`include "sgss_cfg.svh"
interface sgss_blend_if;
  sgss_pkg::sgss_gain_t val1 [`SGSS_NUM_GAINS];
  sgss_pkg::sgss_gain_t val2 [`SGSS_NUM_GAINS];
  sgss_pkg::sgss_gain_t gain [`SGSS_NUM_GAINS];
  sgss_pkg::sgss_weight_t w_main;
  sgss_pkg::sgss_weight_t w_mf;
  modport ctrl (output val1, output val2, output w_main, output w_mf, input gain);
  modport blend (input val1, input val2, input w_main, input w_mf, output gain);
endinterface

// ==== pkg/sgss_cfg.svh ====
// constants of the servo gain set switcher: offsets, fields, resets and timing
`ifndef SGSS_CFG_SVH
`define SGSS_CFG_SVH

`define SGSS_NUM_GAINS 7
`define SGSS_IDX_SPD_GAIN 0
`define SGSS_IDX_SPD_INTEG 1
`define SGSS_IDX_POS_GAIN 2
`define SGSS_IDX_TRQ_FILT 3
`define SGSS_IDX_MF_GAIN 4
`define SGSS_IDX_MF_COMP 5
`define SGSS_IDX_FRICTION 6

`define SGSS_ADR_CONFIG 6'h00
`define SGSS_ADR_STATUS 6'h01
`define SGSS_ADR_WAIT 6'h02
`define SGSS_ADR_RAMP 6'h03
`define SGSS_ADR_GAIN_BASE 6'h04

`define SGSS_CFG_MODE_LSB 0
`define SGSS_CFG_COND_LSB 4
`define SGSS_CFG_SPD_LSB 8
`define SGSS_CFG_MASK 32'h0000_03ff

`define SGSS_STS_TARGET 0
`define SGSS_STS_WAITING 1
`define SGSS_STS_RAMPING 2
`define SGSS_STS_MF_SET2 3
`define SGSS_STS_AUTO_ON 4
`define SGSS_STS_WEIGHT_LSB 8

`define SGSS_MODE_MANUAL 4'h0
`define SGSS_MODE_AUTO 4'h2
`define SGSS_COND_POSITIONING_COMPLETED_ON 4'h0
`define SGSS_COND_POSITIONING_COMPLETED_OFF 4'h1
`define SGSS_COND_NEAR_ON 4'h2
`define SGSS_COND_NEAR_OFF 4'h3
`define SGSS_COND_FILT_IDLE 4'h4
`define SGSS_COND_REF_ON 4'h5
`define SGSS_SPD_PI 2'h0
`define SGSS_SPD_IP 2'h1

`define SGSS_RST_CONFIG 32'h0000_0000
`define SGSS_RST_SPD_GAIN 16'h0190
`define SGSS_RST_SPD_INTEG 16'h07d0
`define SGSS_RST_POS_GAIN 16'h0190
`define SGSS_RST_TRQ_FILT 16'h0064
`define SGSS_RST_MF_GAIN 16'h01f4
`define SGSS_RST_MF_COMP 16'h03e8
`define SGSS_RST_FRICTION 16'h0064
`define SGSS_RST_TIMES 16'h0000

`define SGSS_WEIGHT_FULL 17'h10000
`define SGSS_TIME_UNIT_NS 1000000
`define SGSS_CLK_PERIOD_NS 4

`endif

// ==== pkg/sgss_pkg.sv ====
// types of the servo gain set switcher
package sgss_pkg;
  typedef logic [15:0] sgss_gain_t;
  typedef logic [16:0] sgss_weight_t;
  typedef enum logic [1:0] {
    SGSS_IDLE,
    SGSS_WAITING,
    SGSS_RAMPING
  } sgss_state_e;
endpackage
